// [src/mps_regs.sv]
`timescale 1ns/1ps
`include "mps_params.svh"
module mps_regs
  import mps_pkg::*;
#(
  parameter int NCHAN   = 8,
  parameter int NENTRY  = 32
) (
  input  wire logic        SYS_CLK,
  input  wire logic        ARST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [11:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             WB_ERR_O,
  input  wire logic        RX_FRAME_DONE,
  input  wire logic        RX_ADDR_MATCH,
  input  wire logic        RX_CONTROL_FRAME,
  input  wire logic [15:0] RX_FRAME_LEN,
  input  wire logic        RX_FRAME_ERROR,
  input  wire logic        RX_OVERRUN,
  input  wire logic [47:0] RX_DEST_ADDR,
  input  wire logic [NCHAN-1:0] TX_DESC_DONE,
  input  wire logic [NCHAN-1:0] RX_DESC_DONE,
  input  wire logic [31:0] DESC_DONE_ADDR,
  output logic [NCHAN-1:0] TX_DMA_START,
  output logic [NCHAN-1:0] RX_DMA_ALLOW,
  output logic [NCHAN-1:0] TX_CHAN_INT,
  output logic [NCHAN-1:0] RX_CHAN_INT,
  output logic             STAT_INT,
  output logic [31:0]      TX_HEAD [NCHAN],
  output logic [31:0]      RX_HEAD [NCHAN],
  input  wire logic [4:0]  RAM_RD_IDX,
  output logic [52:0]      RAM_RD_ENTRY
);
  localparam int CLR_CNT = `MPS_CLR_DELAY;

  function automatic logic [31:0] dec_sat(input logic [31:0] cur, input logic [31:0] wv);
    dec_sat = (wv > cur) ? 32'h00000000 : cur - wv;
  endfunction

  function automatic logic [31:0] wr_cnt(input logic gig, input logic [31:0] cur,
                                         input logic [31:0] wv);
    wr_cnt = gig ? dec_sat(cur, wv) : wv;
  endfunction

  // bus request decode
  logic        req;
  logic        wr;
  logic        rd;
  logic        ack;
  logic        err;
  logic [31:0] rdata;
  logic [2:0]  ch;
  logic        hit;
  logic [31:0] rmux;
  // state
  logic [4:0]  index;
  logic [31:0] addr_hi;
  logic [20:0] addr_lo;
  mps_entry_t  ram [NENTRY];
  logic [1:0]  ctl;
  logic [15:0] maxlen;
  logic [31:0] good_cnt;
  logic [31:0] bcast_cnt;
  logic [31:0] tx_cp [NCHAN];
  logic [31:0] rx_cp [NCHAN];
  logic [31:0] tx_last [NCHAN];
  logic [31:0] rx_last [NCHAN];
  logic [NCHAN-1:0] tx_int;
  logic [NCHAN-1:0] rx_int;
  logic [NCHAN-1:0] tx_start;
  logic [NCHAN-1:0] rx_allow;
  logic [15:0] hdp_err;
  mps_clr_t    clr_st;
  logic [5:0]  clr_cnt;
  // next values
  logic [4:0]  next_index;
  logic [31:0] next_addr_hi;
  logic [20:0] next_addr_lo;
  logic [1:0]  next_ctl;
  logic [15:0] next_maxlen;
  logic [31:0] next_good_cnt;
  logic [31:0] next_bcast_cnt;
  logic [NCHAN-1:0] next_tx_int;
  logic [NCHAN-1:0] next_rx_int;
  logic [NCHAN-1:0] next_tx_start;
  logic [NCHAN-1:0] next_rx_allow;
  logic [15:0] next_hdp_err;
  mps_clr_t    next_clr_st;
  logic [5:0]  next_clr_cnt;
  logic        ram_we;
  logic        good_ev;
  logic        bcast_ev;
  logic [31:0] tx_head_q [NCHAN];
  logic [31:0] rx_head_q [NCHAN];

  assign req = WB_CYC_I & WB_STB_I & ~ack & ~err;
  assign wr  = req & WB_WE_I & hit;
  assign rd  = req & ~WB_WE_I & hit;
  assign ch  = WB_ADR_I[4:2];
  assign WB_ACK_O = ack;
  assign WB_ERR_O = err;
  assign WB_DAT_O = rdata;
  assign TX_CHAN_INT = tx_int;
  assign RX_CHAN_INT = rx_int;
  assign TX_DMA_START = tx_start;
  assign RX_DMA_ALLOW = rx_allow;
  assign TX_HEAD = tx_head_q;
  assign RX_HEAD = rx_head_q;
  assign RAM_RD_ENTRY = ram[RAM_RD_IDX];
  // overrun is deliberately not an input to either event
  assign good_ev = RX_FRAME_DONE & RX_ADDR_MATCH & ~RX_FRAME_ERROR &
                   (RX_FRAME_LEN >= `MPS_MIN_FRAME) & (RX_FRAME_LEN <= maxlen);
  assign bcast_ev = good_ev & (RX_DEST_ADDR == 48'hffffffffffff);
  assign STAT_INT = ctl[`MPS_CTL_STATEN_BIT] &
                    ((good_cnt >= `MPS_HALF_SCALE) | (bcast_cnt >= `MPS_HALF_SCALE));

  always_comb begin
    hit  = 1'b1;
    rmux = 32'h00000000;
    if (WB_ADR_I == `MPS_OFF_INDEX) begin
      rmux = {27'h0000000, index};
    end else if (WB_ADR_I == `MPS_OFF_ADDR_HI) begin
      rmux = addr_hi;
    end else if (WB_ADR_I == `MPS_OFF_ADDR_LO) begin
      rmux = {11'h000, addr_lo};
    end else if (WB_ADR_I == `MPS_OFF_CONTROL) begin
      rmux = {30'h00000000, ctl};
    end else if (WB_ADR_I == `MPS_OFF_MAXLEN) begin
      rmux = {16'h0000, maxlen};
    end else if (WB_ADR_I == `MPS_OFF_STATUS) begin
      rmux = {31'h00000000, STAT_INT};
    end else if (WB_ADR_I == `MPS_OFF_ERROR) begin
      rmux = {16'h0000, hdp_err};
    end else if (WB_ADR_I == `MPS_OFF_DONE) begin
      rmux = {29'h00000000, clr_st};
    end else if (WB_ADR_I == `MPS_OFF_RAM_RD) begin
      rmux = ram[index][31:0];
    end else if (WB_ADR_I == `MPS_OFF_GOOD) begin
      rmux = good_cnt;
    end else if (WB_ADR_I == `MPS_OFF_BCAST) begin
      rmux = bcast_cnt;
    end else if (WB_ADR_I[11:5] == `MPS_OFF_TX_HDP >> 5) begin
      rmux = tx_head_q[ch];
    end else if (WB_ADR_I[11:5] == `MPS_OFF_RX_HDP >> 5) begin
      rmux = rx_head_q[ch];
    end else if (WB_ADR_I[11:5] == `MPS_OFF_TX_CP >> 5) begin
      rmux = tx_cp[ch];
    end else if (WB_ADR_I[11:5] == `MPS_OFF_RX_CP >> 5) begin
      rmux = rx_cp[ch];
    end else begin
      hit = 1'b0;
    end
  end

  always_comb begin
    next_index     = index;
    next_addr_hi   = addr_hi;
    next_addr_lo   = addr_lo;
    next_ctl       = ctl;
    next_maxlen    = maxlen;
    next_hdp_err   = hdp_err;
    next_tx_start  = '0;
    next_rx_allow  = rx_allow;
    next_tx_int    = tx_int;
    next_rx_int    = rx_int;
    ram_we         = 1'b0;
    if (wr) begin
      if (WB_ADR_I == `MPS_OFF_INDEX) begin
        next_index = WB_DAT_I[4:0];
      end else if (WB_ADR_I == `MPS_OFF_ADDR_HI) begin
        next_addr_hi = WB_DAT_I;
      end else if (WB_ADR_I == `MPS_OFF_ADDR_LO) begin
        next_addr_lo = WB_DAT_I[20:0];
        ram_we = 1'b1;
      end else if (WB_ADR_I == `MPS_OFF_CONTROL) begin
        next_ctl = WB_DAT_I[1:0];
      end else if (WB_ADR_I == `MPS_OFF_MAXLEN) begin
        next_maxlen = WB_DAT_I[15:0];
      end else if (WB_ADR_I == `MPS_OFF_ERROR) begin
        next_hdp_err = hdp_err & ~WB_DAT_I[15:0];
      end else if (WB_ADR_I[11:5] == `MPS_OFF_TX_HDP >> 5) begin
        next_tx_start[ch] = 1'b1;
        if (tx_head_q[ch] != 32'h00000000) begin
          next_hdp_err[ch] = 1'b1;
        end
      end else if (WB_ADR_I[11:5] == `MPS_OFF_RX_HDP >> 5) begin
        next_rx_allow[ch] = 1'b1;
        if (rx_head_q[ch] != 32'h00000000) begin
          next_hdp_err[NCHAN+ch] = 1'b1;
        end
      end else if (WB_ADR_I[11:5] == `MPS_OFF_TX_CP >> 5) begin
        if (WB_DAT_I == tx_last[ch]) begin
          next_tx_int[ch] = 1'b0;
        end
      end else if (WB_ADR_I[11:5] == `MPS_OFF_RX_CP >> 5) begin
        if (WB_DAT_I == rx_last[ch]) begin
          next_rx_int[ch] = 1'b0;
        end
      end
    end
    // a completion in the same cycle as a clearing write keeps the interrupt
    next_tx_int = next_tx_int | TX_DESC_DONE;
    next_rx_int = next_rx_int | RX_DESC_DONE;
  end

  always_comb begin
    next_clr_st  = clr_st;
    next_clr_cnt = clr_cnt;
    case (clr_st)
      MPS_CLR_WAIT: begin
        next_clr_cnt = clr_cnt + 6'h01;
        if (clr_cnt == 6'(CLR_CNT - 1)) begin
          next_clr_st = MPS_CLR_DO;
        end
      end
      MPS_CLR_DO:  next_clr_st = MPS_CLR_RUN;
      MPS_CLR_RUN: next_clr_st = MPS_CLR_RUN;
      default:     next_clr_st = MPS_CLR_WAIT;
    endcase
  end

  always_comb begin
    next_good_cnt  = good_cnt + {31'h00000000, good_ev};
    next_bcast_cnt = bcast_cnt + {31'h00000000, bcast_ev};
    // full-word writes only; partial byte lanes leave counters alone
    if (wr && WB_SEL_I == 4'hf && WB_ADR_I == `MPS_OFF_GOOD) begin
      next_good_cnt = wr_cnt(ctl[`MPS_CTL_GIG_BIT], good_cnt, WB_DAT_I);
    end
    if (wr && WB_SEL_I == 4'hf && WB_ADR_I == `MPS_OFF_BCAST) begin
      next_bcast_cnt = wr_cnt(ctl[`MPS_CTL_GIG_BIT], bcast_cnt, WB_DAT_I);
    end
    if (clr_st == MPS_CLR_DO) begin
      next_good_cnt  = 32'h00000000;
      next_bcast_cnt = 32'h00000000;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      index     <= 5'h00;
      addr_hi   <= 32'h00000000;
      addr_lo   <= 21'h000000;
      ctl       <= 2'h0;
      maxlen    <= `MPS_MAXLEN_RESET;
      hdp_err   <= 16'h0000;
      tx_start  <= '0;
      rx_allow  <= '0;
      tx_int    <= '0;
      rx_int    <= '0;
      good_cnt  <= 32'h00000000;
      bcast_cnt <= 32'h00000000;
      clr_st    <= MPS_CLR_WAIT;
      clr_cnt   <= 6'h00;
      ack       <= 1'b0;
      err       <= 1'b0;
      rdata     <= 32'h00000000;
      for (int i = 0; i < NCHAN; i++) begin
        tx_head_q[i] <= 32'h00000000;
        rx_head_q[i] <= 32'h00000000;
        tx_cp[i]     <= 32'h00000000;
        rx_cp[i]     <= 32'h00000000;
        tx_last[i]   <= 32'h00000000;
        rx_last[i]   <= 32'h00000000;
      end
    end else begin
      index     <= next_index;
      addr_hi   <= next_addr_hi;
      addr_lo   <= next_addr_lo;
      ctl       <= next_ctl;
      maxlen    <= next_maxlen;
      hdp_err   <= next_hdp_err;
      tx_start  <= next_tx_start;
      rx_allow  <= next_rx_allow;
      tx_int    <= next_tx_int;
      rx_int    <= next_rx_int;
      good_cnt  <= next_good_cnt;
      bcast_cnt <= next_bcast_cnt;
      clr_st    <= next_clr_st;
      clr_cnt   <= next_clr_cnt;
      ack       <= req & hit;
      err       <= req & ~hit;
      rdata     <= rd ? rmux : 32'h00000000;
      for (int i = 0; i < NCHAN; i++) begin
        if (wr && WB_ADR_I[11:5] == `MPS_OFF_TX_HDP >> 5 && ch == 3'(i)) begin
          tx_head_q[i] <= WB_DAT_I;
        end
        if (wr && WB_ADR_I[11:5] == `MPS_OFF_RX_HDP >> 5 && ch == 3'(i)) begin
          rx_head_q[i] <= WB_DAT_I;
        end
        if (wr && WB_ADR_I[11:5] == `MPS_OFF_TX_CP >> 5 && ch == 3'(i)) begin
          tx_cp[i] <= WB_DAT_I;
        end
        if (wr && WB_ADR_I[11:5] == `MPS_OFF_RX_CP >> 5 && ch == 3'(i)) begin
          rx_cp[i] <= WB_DAT_I;
        end
        if (TX_DESC_DONE[i]) begin
          tx_last[i] <= DESC_DONE_ADDR;
        end
        if (RX_DESC_DONE[i]) begin
          rx_last[i] <= DESC_DONE_ADDR;
        end
      end
    end
  end

  // address ram has no reset; software loads every entry before use
  always_ff @(posedge SYS_CLK) begin
    if (ram_we) begin
      ram[index] <= {next_addr_lo, addr_hi};
    end
  end

  a_ram_commit: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    ram_we |=> ram[$past(index)] == {$past(WB_DAT_I[20:0]), $past(addr_hi)})
    else $error("address entry not committed");
  a_clear_time: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    $rose(clr_st == MPS_CLR_DO) |-> clr_cnt == 6'(CLR_CNT))
    else $error("statistics clear at wrong time");
  a_clear_zero: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    clr_st == MPS_CLR_DO |=> good_cnt == 32'h0 && bcast_cnt == 32'h0)
    else $error("statistics not cleared");
  a_dec_write: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr && WB_SEL_I == 4'hf && WB_ADR_I == `MPS_OFF_GOOD && ctl[0] && clr_st == MPS_CLR_RUN
    |=> good_cnt == dec_sat($past(good_cnt), $past(WB_DAT_I)))
    else $error("decrement write wrong");
  a_direct_write: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr && WB_SEL_I == 4'hf && WB_ADR_I == `MPS_OFF_BCAST && !ctl[0] && clr_st == MPS_CLR_RUN
    |=> bcast_cnt == $past(WB_DAT_I))
    else $error("direct write wrong");
  a_stat_int: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    ctl[1] && good_cnt[31] |-> STAT_INT)
    else $error("statistics interrupt missing");
  a_stat_drop: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !good_cnt[31] && !bcast_cnt[31] |-> !STAT_INT)
    else $error("statistics interrupt stuck");
  a_count_wrap: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    good_cnt == 32'hffffffff && good_ev && !wr && clr_st == MPS_CLR_RUN |=> good_cnt == 32'h0)
    else $error("counter did not wrap");
  a_tx_start: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr && WB_ADR_I[11:5] == 7'h08 |=> TX_DMA_START[$past(ch)] ##1 !TX_DMA_START[$past(ch, 2)])
    else $error("transmit start not pulsed");
  a_hdp_error: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    wr && WB_ADR_I[11:5] == 7'h09 && rx_head_q[ch] != 32'h0 |=> hdp_err[NCHAN + $past(ch)])
    else $error("head pointer error not flagged");
  a_int_hold: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    tx_int[0] && !(wr && WB_ADR_I == `MPS_OFF_TX_CP && WB_DAT_I == tx_last[0]) |=> tx_int[0])
    else $error("channel interrupt dropped early");
  a_bcast_good: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    bcast_ev |-> good_ev)
    else $error("broadcast without good frame");

  c_ram_write: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) ram_we);
  c_stat_int:  cover property (@(posedge SYS_CLK) disable iff (!ARST_N) $fell(STAT_INT));
  c_int_clear: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) $fell(rx_int[0]));
  c_bcast:     cover property (@(posedge SYS_CLK) disable iff (!ARST_N) bcast_ev);
endmodule // mps_regs

// [src/mps_params.svh]
`ifndef MPS_PARAMS_SVH
`define MPS_PARAMS_SVH
// register byte offsets
`define MPS_OFF_INDEX     12'h000
`define MPS_OFF_ADDR_HI   12'h004
`define MPS_OFF_ADDR_LO   12'h008
`define MPS_OFF_CONTROL   12'h00c
`define MPS_OFF_MAXLEN    12'h010
`define MPS_OFF_STATUS    12'h014
`define MPS_OFF_ERROR     12'h018
`define MPS_OFF_DONE      12'h01c
`define MPS_OFF_RAM_RD    12'h020
`define MPS_OFF_GOOD      12'h030
`define MPS_OFF_BCAST     12'h034
`define MPS_OFF_TX_HDP    12'h100
`define MPS_OFF_RX_HDP    12'h120
`define MPS_OFF_TX_CP     12'h140
`define MPS_OFF_RX_CP     12'h160
// field positions
`define MPS_LO_VALID_BIT  20
`define MPS_LO_MATCH_BIT  19
`define MPS_LO_CHAN_HI    18
`define MPS_LO_CHAN_LO    16
`define MPS_CTL_GIG_BIT   0
`define MPS_CTL_STATEN_BIT 1
// reset values and figures
`define MPS_MAXLEN_RESET  16'h05ee
`define MPS_MIN_FRAME     16'h0040
`define MPS_HALF_SCALE    32'h80000000
`define MPS_CLR_DELAY     38
`endif

// [src/mps_pkg.sv]
package mps_pkg;
  typedef enum logic [2:0] {
    MPS_CLR_WAIT = 3'b001,
    MPS_CLR_DO   = 3'b010,
    MPS_CLR_RUN  = 3'b100
  } mps_clr_t;
  typedef logic [52:0] mps_entry_t;
endpackage

// [sim/mps_frame_src.sv]
`timescale 1ns/1ps
// receive datapath and dma side of the port, seen from the register block
module mps_frame_src #(
  parameter int NCHAN = 8
) (
  input  wire logic             clk,
  output logic                  frame_done,
  output logic                  addr_match,
  output logic                  ctl_frame,
  output logic [15:0]           frame_len,
  output logic                  frame_err,
  output logic                  overrun,
  output logic [47:0]           dest,
  output logic [NCHAN-1:0]      tx_done,
  output logic [NCHAN-1:0]      rx_done,
  output logic [31:0]           done_addr
);
  initial begin
    frame_done = 1'b0;
    {addr_match, ctl_frame, frame_len, frame_err, overrun, dest} = '0;
    {tx_done, rx_done, done_addr} = '0;
  end
  // qualifiers are only meaningful with the strobe; afterwards show their inverse
  task automatic send_frame(input logic m, input logic c, input logic [15:0] l,
                            input logic e, input logic o, input logic [47:0] d);
    frame_done <= 1'b1;
    {addr_match, ctl_frame, frame_len, frame_err, overrun, dest} <= {m, c, l, e, o, d};
    @(posedge clk);
    frame_done <= 1'b0;
    {addr_match, ctl_frame, frame_len, frame_err, overrun, dest} <= ~{m, c, l, e, o, d};
    @(posedge clk);
  endtask
  task automatic complete(input logic tx, input int ch, input logic [31:0] a);
    if (tx) tx_done[ch] <= 1'b1;
    else rx_done[ch] <= 1'b1;
    done_addr <= a;
    @(posedge clk);
    tx_done <= '0;
    rx_done <= '0;
    done_addr <= ~a;
    @(posedge clk);
  endtask
endmodule // mps_frame_src

// [sim/testbench.sv]
`timescale 1ns/1ps
`include "mps_params.svh"
module testbench;
  typedef struct packed {
    logic m; logic c; logic [15:0] len; logic e; logic o; logic [47:0] dest;
    logic gi; logic bi;
  } mps_row_t;
  logic        sys_clk, arst_n, wb_cyc, wb_stb, wb_we, wb_ack, wb_err;
  logic [11:0] wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat, done_addr, rd, eg, eb;
  logic        fdone, fmatch, fctl, ferr, fovr, er, clr, stat_int;
  logic [15:0] flen;
  logic [47:0] fdest;
  logic [7:0]  txd, rxd, tx_start, rx_allow, tx_int, rx_int, seen;
  logic [31:0] tx_head [8];
  logic [31:0] rx_head [8];
  logic [4:0]  ram_idx;
  logic [52:0] ram_entry;
  int          mismatches, checks;
  // good frames 64..05ee inclusive; overrun and control flag do not matter
  mps_row_t rows [10] = '{
    '{1, 0, 16'h0040, 0, 0, 48'h000012345678, 1, 0}, '{1, 0, 16'h003f, 0, 0, 48'h000012345678, 0, 0},
    '{1, 1, 16'h05ee, 0, 0, 48'h000012345678, 1, 0}, '{1, 0, 16'h05ef, 0, 0, 48'h000012345678, 0, 0},
    '{1, 0, 16'h0100, 1, 0, 48'h000012345678, 0, 0}, '{0, 0, 16'h0100, 0, 0, 48'h000012345678, 0, 0},
    '{1, 0, 16'h0100, 0, 1, 48'h000012345678, 1, 0}, '{1, 0, 16'h0100, 0, 0, 48'hffffffffffff, 1, 1},
    '{1, 0, 16'h0100, 0, 0, 48'hfffffffffffe, 1, 0}, '{1, 0, 16'h003f, 0, 0, 48'hffffffffffff, 0, 0}};

  always #5 sys_clk = ~sys_clk;
  // sticky record of start pulses, so their exact cycle need not be guessed
  always @(posedge sys_clk) seen <= clr ? 8'h00 : (seen | tx_start);

  mps_frame_src #(.NCHAN(8)) i_src (.clk(sys_clk), .frame_done(fdone), .addr_match(fmatch),
    .ctl_frame(fctl), .frame_len(flen), .frame_err(ferr), .overrun(fovr), .dest(fdest),
    .tx_done(txd), .rx_done(rxd), .done_addr(done_addr));
  mps_regs #(.NCHAN(8), .NENTRY(32)) i_dut (.SYS_CLK(sys_clk), .ARST_N(arst_n),
    .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr),
    .WB_SEL_I(wb_sel), .WB_DAT_I(wb_wdat), .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack),
    .WB_ERR_O(wb_err), .RX_FRAME_DONE(fdone), .RX_ADDR_MATCH(fmatch),
    .RX_CONTROL_FRAME(fctl), .RX_FRAME_LEN(flen), .RX_FRAME_ERROR(ferr),
    .RX_OVERRUN(fovr), .RX_DEST_ADDR(fdest), .TX_DESC_DONE(txd), .RX_DESC_DONE(rxd),
    .DESC_DONE_ADDR(done_addr), .TX_DMA_START(tx_start), .RX_DMA_ALLOW(rx_allow),
    .TX_CHAN_INT(tx_int), .RX_CHAN_INT(rx_int), .STAT_INT(stat_int), .TX_HEAD(tx_head),
    .RX_HEAD(rx_head), .RAM_RD_IDX(ram_idx), .RAM_RD_ENTRY(ram_entry));

  task automatic summarize();
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [52:0] exp, input logic [52:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // entered just after a rising edge; ack is read before that edge's updates land
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} <= {1'b1, 1'b1, we, a, d, 4'hf};
    do begin
      @(posedge sys_clk);
      n++;
    end while (!(wb_ack === 1'b1 || wb_err === 1'b1) && n < 50);
    rd = wb_rdat;
    er = wb_err;
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
    @(posedge sys_clk);
  endtask

  initial begin
    {sys_clk, arst_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
    {ram_idx, clr, mismatches, checks, eg, eb} = '0;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    wb(1, `MPS_OFF_GOOD, 32'h5);
    repeat (45) @(posedge sys_clk);
    wb(0, `MPS_OFF_GOOD, 0); chk("good_after_reset", 0, rd);
    wb(0, `MPS_OFF_BCAST, 0); chk("bcast_after_reset", 0, rd);
    wb(0, `MPS_OFF_MAXLEN, 0); chk("maxlen_reset", `MPS_MAXLEN_RESET, rd);
    // every address entry is loaded, marked invalid, before any frame arrives
    for (int k = 0; k < 32; k++) begin
      wb(1, `MPS_OFF_INDEX, 32'(k));
      wb(1, `MPS_OFF_ADDR_HI, 0);
      wb(1, `MPS_OFF_ADDR_LO, 0);
    end
    foreach (rows[i]) begin
      i_src.send_frame(rows[i].m, rows[i].c, rows[i].len, rows[i].e, rows[i].o, rows[i].dest);
      eg += 32'(rows[i].gi);
      eb += 32'(rows[i].bi);
      wb(0, `MPS_OFF_GOOD, 0); chk("good_count", eg, rd);
      wb(0, `MPS_OFF_BCAST, 0); chk("bcast_count", eb, rd);
    end
    // address ram at the top index: nothing lands before the low word
    ram_idx <= 5'd31;
    wb(1, `MPS_OFF_INDEX, 32'd31);
    wb(1, `MPS_OFF_ADDR_HI, 32'h89abcdef);
    wb(1, `MPS_OFF_ADDR_LO, 32'h00151234);
    wb(1, `MPS_OFF_ADDR_HI, 32'h00000000);
    chk("ram_before_lo", {21'h151234, 32'h89abcdef}, ram_entry);
    wb(1, `MPS_OFF_ADDR_LO, 32'hffee5678);
    chk("ram_after_lo", {21'h0e5678, 32'h00000000}, ram_entry);
    for (int n = 0; n < 8; n++) begin
      wb(1, `MPS_OFF_TX_HDP + 12'(4 * n), 0);
      wb(1, `MPS_OFF_RX_HDP + 12'(4 * n), 0);
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      wb(1, `MPS_OFF_TX_HDP + 12'(4 * n), 32'h1000 + 32'(16 * n));
      wb(1, `MPS_OFF_RX_HDP + 12'(4 * n), 32'h2000 + 32'(16 * n));
      repeat (2) @(posedge sys_clk);
      chk("tx_start", 8'h01 << n, seen);
      chk("tx_head", 32'h1000 + 32'(16 * n), tx_head[n]);
      chk("rx_head", 32'h2000 + 32'(16 * n), rx_head[n]);
      chk("rx_allow", (9'h002 << n) - 9'h001, rx_allow);
    end
    wb(0, `MPS_OFF_ERROR, 0); chk("hdp_err_none", 0, rd);
    wb(1, `MPS_OFF_TX_HDP + 12'h00c, 32'h3000);
    wb(1, `MPS_OFF_RX_HDP + 12'h01c, 32'h3000);
    wb(0, `MPS_OFF_ERROR, 0); chk("hdp_err", 32'h00008008, rd);
    wb(1, `MPS_OFF_ERROR, 32'hffffffff);
    wb(0, `MPS_OFF_ERROR, 0); chk("hdp_err_clr", 0, rd);
    i_src.complete(1, 2, 32'h4440); chk("tx_int_set", 8'h04, tx_int);
    wb(1, `MPS_OFF_TX_CP + 12'h008, 32'h4444); chk("tx_int_wrong", 8'h04, tx_int);
    wb(1, `MPS_OFF_TX_CP + 12'h008, 32'h4440); chk("tx_int_clr", 0, tx_int);
    i_src.complete(0, 7, 32'h5550); chk("rx_int_set", 8'h80, rx_int);
    wb(1, `MPS_OFF_RX_CP + 12'h01c, 32'h5550); chk("rx_int_clr", 0, rx_int);
    wb(1, `MPS_OFF_CONTROL, 0);
    wb(1, `MPS_OFF_GOOD, 32'h7fffffff);
    wb(0, `MPS_OFF_GOOD, 0); chk("good_direct", 32'h7fffffff, rd);
    i_src.send_frame(1, 0, 16'h0100, 0, 0, 48'h000000000011);
    chk("stat_int_off", 0, stat_int);
    wb(1, `MPS_OFF_CONTROL, 2); chk("stat_int_on", 1, stat_int);
    wb(1, `MPS_OFF_CONTROL, 3);
    wb(1, `MPS_OFF_GOOD, 1);
    wb(0, `MPS_OFF_GOOD, 0); chk("good_dec", 32'h7fffffff, rd);
    chk("stat_int_drop", 0, stat_int);
    wb(1, `MPS_OFF_GOOD, 32'h80000000);
    wb(0, `MPS_OFF_GOOD, 0); chk("good_sat", 0, rd);
    wb(1, `MPS_OFF_CONTROL, 2);
    wb(1, `MPS_OFF_GOOD, 32'hffffffff);
    i_src.send_frame(1, 0, 16'h0100, 0, 0, 48'h000000000011);
    wb(0, `MPS_OFF_GOOD, 0); chk("good_wrap", 0, rd);
    wb(0, 12'h3fc, 0); chk("unmapped_err", 1, er);
    summarize();
  end
endmodule // testbench
